// ### verilog/line_format_pkg.sv
// Constants for the serial line format control block.
// Notes on behaviour
// - Bank-select 0 routes shared low addresses to data registers, 1 to divisor registers.
// - Break-force bit 6 drives the line low from the next bit boundary onward.
// - The transmit FIFO is cleared in the same cycle the line is forced low.
// - After break-force clears, the break ends at the next baud generator edge.
// - Force-parity-error with parity enabled sends an inverted parity bit.
// - Outside multidrop, parity-select 0 means odd parity and 1 means even parity.
// - Parity enable bit 3 adds a parity bit on transmit and checks it on receive.
// - With parity disabled no parity bit is sent, expected or checked.
// - In multidrop the sent parity bit is space for select 0, mark for 1.
// - In multidrop with parity enabled the receiver checks against space parity.
// - The format field low two bits give 5, 6, 7 or 8 data bits.
// - Format codes 000 to 011 send one stop bit, 100 to 111 send two.
// - Multidrop is enabled by modem control bit 5 and only then mark/space applies.
package line_format_pkg;
    localparam logic [7:0] LINE_CONTROL_PORT0_ADDR = 8'hC3;
    localparam logic [7:0] LINE_CONTROL_PORT1_ADDR = 8'hD3;
    localparam logic [7:0] SHARED_LO_PORT0_ADDR = 8'hC0;
    localparam logic [7:0] SHARED_HI_PORT0_ADDR = 8'hC1;
    localparam logic [7:0] SHARED_LO_PORT1_ADDR = 8'hD0;
    localparam logic [7:0] SHARED_HI_PORT1_ADDR = 8'hD1;
    localparam logic [7:0] LINE_CONTROL_RESET = 8'h00;
    localparam int BANK_SEL_BIT = 7;
    localparam int BREAK_BIT = 6;
    localparam int FORCE_PE_BIT = 5;
    localparam int EVEN_SEL_BIT = 4;
    localparam int PARITY_EN_BIT = 3;
    localparam int TWO_STOP_BIT = 2;
    localparam int LEN_HI_BIT = 1;
    localparam int LEN_LO_BIT = 0;
    localparam logic [3:0] MIN_DATA_BITS = 4'h5;
    localparam logic SPACE_LEVEL = 1'b0;
    localparam logic IDLE_LEVEL = 1'b1;

    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_START = 3'h1,
        TX_DATA = 3'h3,
        TX_PARITY = 3'h2,
        TX_STOP = 3'h6,
        TX_BREAK = 3'h7
    } tx_state_t;
endpackage

// ### verilog/line_format_control.sv
// Line control register with a break-capable, parity-aware character transmitter and receive parity check.
`timescale 1ns/1ps
module line_format_control #(
    parameter logic [7:0] LINE_CONTROL_ADDR = line_format_pkg::LINE_CONTROL_PORT0_ADDR,
    parameter logic [7:0] SHARED_LO_ADDR = line_format_pkg::SHARED_LO_PORT0_ADDR,
    parameter logic [7:0] SHARED_HI_ADDR = line_format_pkg::SHARED_HI_PORT0_ADDR
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    output logic o_data_bank_sel,
    output logic o_divisor_bank_sel,
    input wire logic i_multidrop_on,
    input wire logic i_baud_tick,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_ready,
    output logic o_tx_fifo_clear,
    output logic o_txd,
    output logic o_in_break,
    input wire logic i_rx_char_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_parity,
    output logic o_rx_parity_error,
    output logic [3:0] o_data_bits,
    output logic o_parity_on
);
    // Refuse at elaboration an address map in which the line control register hides behind a shared address.
    if (SHARED_LO_ADDR == LINE_CONTROL_ADDR || SHARED_HI_ADDR == LINE_CONTROL_ADDR) begin : g_addr_overlap
        $error("Shared addresses overlap the line control address.");
    end

    logic [7:0] line_control;
    logic [7:0] next_line_control;
    line_format_pkg::tx_state_t tx_state, next_tx_state;
    logic [7:0] shift, next_shift;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic stop_left, next_stop_left;
    logic parity_bit, next_parity_bit;
    logic txd, next_txd;
    logic fifo_clear, next_fifo_clear;
    logic [7:0] rdata, next_rdata;
    logic rx_perr, next_rx_perr;

    logic bank_sel, brk, force_pe, even_sel, parity_en, two_stop, multidrop;
    logic [3:0] data_bits;
    logic [7:0] len_mask;
    logic take;

    assign bank_sel = line_control[line_format_pkg::BANK_SEL_BIT];
    assign brk = line_control[line_format_pkg::BREAK_BIT];
    assign force_pe = line_control[line_format_pkg::FORCE_PE_BIT];
    assign even_sel = line_control[line_format_pkg::EVEN_SEL_BIT];
    assign parity_en = line_control[line_format_pkg::PARITY_EN_BIT];
    assign two_stop = line_control[line_format_pkg::TWO_STOP_BIT];
    assign multidrop = i_multidrop_on;
    assign data_bits = line_format_pkg::MIN_DATA_BITS +
        {2'b00, line_control[line_format_pkg::LEN_HI_BIT:line_format_pkg::LEN_LO_BIT]};
    assign len_mask = 8'hFF >> (4'h8 - data_bits);

    // Tx parity: fixed mark/space in multidrop, else odd/even, optionally inverted.
    function automatic logic tx_parity(input logic [7:0] d);
        logic p;
        p = 1'b0;
        if (multidrop) begin
            p = even_sel;
        end else begin
            p = even_sel ? ^(d & len_mask) : ~^(d & len_mask);
        end
        return p ^ force_pe;
    endfunction

    // Shared low addresses follow the bank-select bit.
    always_comb begin
        o_data_bank_sel = (i_io_addr == SHARED_LO_ADDR || i_io_addr == SHARED_HI_ADDR) && !bank_sel;
        o_divisor_bank_sel = (i_io_addr == SHARED_LO_ADDR || i_io_addr == SHARED_HI_ADDR) && bank_sel;
    end

    always_comb begin
        next_line_control = line_control;
        next_rdata = rdata;
        if (i_io_wr && i_io_addr == LINE_CONTROL_ADDR) begin
            next_line_control = i_io_wdata;
        end
        if (i_io_rd && i_io_addr == LINE_CONTROL_ADDR) begin
            next_rdata = line_control;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            line_control <= line_format_pkg::LINE_CONTROL_RESET;
            rdata <= 8'h00;
        end else begin
            line_control <= next_line_control;
            rdata <= next_rdata;
        end
    end

    // A character is taken only at a bit boundary while idle and not in break.
    assign take = i_baud_tick && tx_state == line_format_pkg::TX_IDLE && !brk && i_tx_valid;

    always_comb begin
        next_tx_state = tx_state;
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_stop_left = stop_left;
        next_parity_bit = parity_bit;
        next_txd = txd;
        next_fifo_clear = 1'b0;
        if (i_baud_tick) begin
            if (brk && tx_state != line_format_pkg::TX_BREAK) begin
                next_fifo_clear = 1'b1;
                next_tx_state = line_format_pkg::TX_BREAK;
                next_txd = line_format_pkg::SPACE_LEVEL;
            end else begin
                unique case (tx_state)
                    line_format_pkg::TX_IDLE: begin
                        next_txd = line_format_pkg::IDLE_LEVEL;
                        if (take) begin
                            next_shift = i_tx_data;
                            next_parity_bit = tx_parity(i_tx_data);
                            next_bit_cnt = data_bits;
                            next_stop_left = two_stop;
                            next_txd = 1'b0;
                            next_tx_state = line_format_pkg::TX_START;
                        end
                    end
                    line_format_pkg::TX_START, line_format_pkg::TX_DATA: begin
                        if (bit_cnt == 4'h0) begin
                            if (parity_en) begin
                                next_txd = parity_bit;
                                next_tx_state = line_format_pkg::TX_PARITY;
                            end else begin
                                next_txd = line_format_pkg::IDLE_LEVEL;
                                next_tx_state = line_format_pkg::TX_STOP;
                            end
                        end else begin
                            next_txd = shift[0];
                            next_shift = {1'b0, shift[7:1]};
                            next_bit_cnt = bit_cnt - 4'h1;
                            next_tx_state = line_format_pkg::TX_DATA;
                        end
                    end
                    line_format_pkg::TX_PARITY: begin
                        next_txd = line_format_pkg::IDLE_LEVEL;
                        next_tx_state = line_format_pkg::TX_STOP;
                    end
                    line_format_pkg::TX_STOP: begin
                        if (stop_left) begin
                            next_stop_left = 1'b0;
                        end else begin
                            next_tx_state = line_format_pkg::TX_IDLE;
                        end
                    end
                    line_format_pkg::TX_BREAK: begin
                        if (!brk) begin
                            next_txd = line_format_pkg::IDLE_LEVEL;
                            next_tx_state = line_format_pkg::TX_IDLE;
                        end
                    end
                    default: begin
                        next_tx_state = line_format_pkg::TX_IDLE;
                        next_txd = line_format_pkg::IDLE_LEVEL;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_state <= line_format_pkg::TX_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            stop_left <= 1'b0;
            parity_bit <= 1'b0;
            txd <= line_format_pkg::IDLE_LEVEL;
            fifo_clear <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            stop_left <= next_stop_left;
            parity_bit <= next_parity_bit;
            txd <= next_txd;
            fifo_clear <= next_fifo_clear;
        end
    end

    // Receive parity check while parity is enabled; multidrop compares against space.
    always_comb begin
        next_rx_perr = rx_perr;
        if (i_rx_char_valid) begin
            if (!parity_en) begin
                next_rx_perr = 1'b0;
            end else if (multidrop) begin
                next_rx_perr = i_rx_parity != line_format_pkg::SPACE_LEVEL;
            end else begin
                next_rx_perr = i_rx_parity != (even_sel ? ^(i_rx_data & len_mask) : ~^(i_rx_data & len_mask));
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_perr <= 1'b0;
        end else begin
            rx_perr <= next_rx_perr;
        end
    end

    assign o_io_rdata = rdata;
    assign o_txd = txd;
    assign o_tx_fifo_clear = fifo_clear;
    assign o_in_break = tx_state == line_format_pkg::TX_BREAK;
    assign o_tx_ready = take;
    assign o_rx_parity_error = rx_perr;
    assign o_data_bits = data_bits;
    assign o_parity_on = parity_en;

    break_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        tx_state == line_format_pkg::TX_BREAK |-> !o_txd)
        else $error("Line not low during break.");
    break_boundary_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        $rose(o_in_break) |-> $past(i_baud_tick))
        else $error("Break began off a bit boundary.");
    fifo_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        $rose(o_in_break) |-> o_tx_fifo_clear)
        else $error("FIFO not cleared on break entry.");
    break_exit_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        o_in_break && !brk && i_baud_tick |=> !o_in_break && o_txd)
        else $error("Break not left at baud edge.");
    no_parity_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        $changed(tx_state) && tx_state == line_format_pkg::TX_PARITY |-> $past(parity_en))
        else $error("Parity bit sent while disabled.");
    md_rx_space_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_rx_char_valid && parity_en && multidrop && !i_rx_parity |=> !o_rx_parity_error)
        else $error("Space parity flagged in multidrop.");
    stop_two_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        take && two_stop |=> stop_left)
        else $error("Second stop bit not armed.");
    bank_decode_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        !(o_data_bank_sel && o_divisor_bank_sel))
        else $error("Both banks selected.");
    md_parity_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        take && multidrop && !force_pe |=> parity_bit == $past(even_sel))
        else $error("Multidrop parity level wrong.");

    break_cov_c: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n) $fell(o_in_break));
    char_cov_c: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n) take);
    perr_cov_c: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n) $rose(o_rx_parity_error));
endmodule // line_format_control

// ### sim/remote_station.sv
// Remote serial station model that decodes each character seen on the transmit line.
`timescale 1ns/1ps
module remote_station (
    input wire logic i_sys_clk,
    input wire logic i_baud_tick,
    input wire logic i_txd,
    input wire logic i_hold,
    input wire logic [3:0] i_data_bits,
    input wire logic i_parity_on,
    input wire logic i_two_stop,
    output logic o_got_valid,
    output logic [7:0] o_got_data,
    output logic o_got_parity,
    output logic o_got_stop_ok
);
    int pos = -1;
    // Each tick edge samples the bit that stood during the period just ended.
    always @(posedge i_sys_clk) begin
        o_got_valid <= 1'b0;
        if (i_hold) begin
            pos <= -1;
        end else if (i_baud_tick && pos < 0) begin
            if (i_txd == 1'b0) begin
                pos <= 0;
                o_got_stop_ok <= 1'b1;
                o_got_data <= 8'h00;
            end
        end else if (i_baud_tick) begin
            if (pos < i_data_bits) begin
                o_got_data[pos] <= i_txd;
            end else if (i_parity_on && pos == i_data_bits) begin
                o_got_parity <= i_txd;
            end else begin
                o_got_stop_ok <= o_got_stop_ok & i_txd;
            end
            pos <= (pos == i_data_bits + i_parity_on + i_two_stop) ? -1 : pos + 1;
            o_got_valid <= (pos == i_data_bits + i_parity_on + i_two_stop);
        end
    end
endmodule // remote_station

// ### sim/tb.sv
// Self-checking bench for the line format control block and its remote station.
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic md = 1'b0;
    logic tick = 1'b0;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic rx_par = 1'b0;
    logic hold = 1'b1;
    logic b2b = 1'b0;
    logic [7:0] lcr = 8'h00;
    logic [7:0] rdata, got_data;
    logic [3:0] data_bits;
    logic data_sel, div_sel, tx_ready, fifo_clear, txd, in_break, rx_err, par_on, got_valid, got_par, got_ok;
    logic [8:0] exp_q[$];
    logic [8:0] e;
    int errors = 0;
    int checked = 0;
    int ticks = 0;
    int takes = 0;
    int last_take = 0;
    int clears = 0;
    int div = 0;

    line_format_control u_line_format_control (.i_sys_clk(clk), .i_reset_n(reset_n), .i_io_addr(addr),
        .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata), .o_io_rdata(rdata), .o_data_bank_sel(data_sel),
        .o_divisor_bank_sel(div_sel), .i_multidrop_on(md), .i_baud_tick(tick), .i_tx_valid(tx_valid),
        .i_tx_data(tx_data), .o_tx_ready(tx_ready), .o_tx_fifo_clear(fifo_clear), .o_txd(txd),
        .o_in_break(in_break), .i_rx_char_valid(rx_valid), .i_rx_data(rx_data), .i_rx_parity(rx_par),
        .o_rx_parity_error(rx_err), .o_data_bits(data_bits), .o_parity_on(par_on));
    remote_station u_remote_station (.i_sys_clk(clk), .i_baud_tick(tick), .i_txd(txd), .i_hold(hold),
        .i_data_bits({2'b00, lcr[1:0]} + 4'h5), .i_parity_on(lcr[3]), .i_two_stop(lcr[2]),
        .o_got_valid(got_valid), .o_got_data(got_data), .o_got_parity(got_par), .o_got_stop_ok(got_ok));

    always #25 clk = ~clk;
    always @(negedge clk) begin
        div = (div + 1) % 4;
        tick = (div == 0);
    end

    function automatic logic [7:0] mask();
        return 8'hFF >> (3 - lcr[1:0]);
    endfunction
    function automatic logic tx_par(input logic [7:0] d);
        logic p;
        p = lcr[4] ? ^(d & mask()) : ~^(d & mask());
        p = md ? lcr[4] : p;
        return p ^ lcr[5];
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] exp);
        @(negedge clk);
        addr = 8'hC3;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        check(rdata, exp);
    endtask
    task automatic send(input logic [7:0] d);
        int t0;
        t0 = takes;
        @(negedge clk);
        tx_valid = 1'b1;
        tx_data = d;
        for (int w = 0; w < 100 && takes == t0; w++) @(negedge clk);
        tx_valid = 1'b0;
        check(8'(takes - t0), 8'h01);
    endtask
    task automatic rx(input logic [7:0] d, input logic p);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data = d;
        rx_par = p;
        @(negedge clk);
        rx_valid = 1'b0;
        check(rx_err, !lcr[3] ? 1'b0 : md ? p : lcr[4] ? ^{d & mask(), p} : ~^{d & mask(), p});
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (tx_ready === 1'b1) begin
            exp_q.push_back({tx_par(tx_data), tx_data & mask()});
            check(in_break, 1'b0);
            if (b2b) check(8'(ticks - last_take), 8'(lcr[1:0] + 8 + lcr[3] + lcr[2]));
            last_take = ticks;
            takes++;
        end
        if (tick) ticks++;
        if (fifo_clear === 1'b1) clears++;
        if (in_break === 1'b1) check(txd, 1'b0);
        if (got_valid === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check(got_data, e[7:0]);
            check(got_ok, 1'b1);
            if (lcr[3]) check(got_par, e[8]);
        end else if (got_valid === 1'b1) begin
            check(8'h01, 8'h00);
        end
    end

    initial begin
        #2000000;
        errors++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(47596));
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        hold = 1'b0;
        reg_rd(8'h00);
        for (int b = 0; b < 2; b++) begin
            reg_wr(8'hC3, {b[0], 7'h03});
            addr = 8'hC1;
            #1 check({data_sel, div_sel}, {~b[0], b[0]});
            addr = 8'hC2;
            #1 check({data_sel, div_sel}, 8'h00);
        end
        for (int c = 0; c < 8; c++) begin
            lcr = {2'b00, 3'($urandom), c[2:0]};
            reg_wr(8'hC3, lcr);
            reg_rd(lcr);
            check(data_bits, {2'b00, lcr[1:0]} + 4'h5);
            check(par_on, lcr[3]);
        end
        reg_wr(8'hC4, 8'hFF);
        reg_rd(lcr);
        for (int i = 0; i < 16; i++) begin
            lcr = 8'($urandom) & 8'h3F;
            md = 1'($urandom);
            reg_wr(8'hC3, lcr);
            b2b = 1'b0;
            send(8'($urandom));
            b2b = 1'b1;
            send(8'($urandom));
            for (int w = 0; w < 100 && exp_q.size() > 0; w++) @(negedge clk);
            check(8'(exp_q.size()), 8'h00);
            rx(8'($urandom), 1'($urandom));
            rx(8'($urandom), 1'($urandom));
        end
        hold = 1'b1;
        lcr = 8'h43;
        reg_wr(8'hC3, lcr);
        for (int w = 0; w < 8 && in_break !== 1'b1; w++) @(negedge clk);
        // The clear pulse is counted at the edge after it is launched.
        @(negedge clk);
        check(in_break, 1'b1);
        check(8'(clears), 8'h01);
        tx_valid = 1'b1;
        repeat (40) @(negedge clk);
        tx_valid = 1'b0;
        lcr = 8'h03;
        reg_wr(8'hC3, lcr);
        for (int w = 0; w < 5 && in_break !== 1'b0; w++) @(negedge clk);
        check(in_break, 1'b0);
        check(txd, 1'b1);
        hold = 1'b0;
        b2b = 1'b0;
        send(8'hA5);
        for (int w = 0; w < 100 && exp_q.size() > 0; w++) @(negedge clk);
        check(8'(exp_q.size()), 8'h00);
        tally_and_finish();
    end
endmodule // tb
